/* common/asd_defines.svh */
// constants for the angle sensor configuration bank and decoder
`ifndef ASD_DEFINES_SVH
`define ASD_DEFINES_SVH
// word addresses in the working ram
`define ASD_ADDR_ZERO      4'h2
`define ASD_ADDR_SPAN      4'h3
`define ASD_ADDR_THRESH    4'h4
`define ASD_ADDR_THERMAL   4'h6
`define ASD_ADDR_OPCFG     4'h7
`define ASD_ADDR_DIAGCFG   4'h8
`define ASD_ADDR_CLAMP     4'h9
`define ASD_NUM_WORDS      16
// commands
`define ASD_CMD_WRITE_HI   4'h0
`define ASD_CMD_READ_HI    4'h1
`define ASD_CMD_PROGRAM    8'h30
// reset values of the coined registers
`define ASD_RST_THERMAL    16'hFAF8
`define ASD_RST_OPCFG      16'h4046
`define ASD_RST_DIAGCFG    16'h0704
`define ASD_RST_CLAMP      16'h00FF
`define ASD_RST_ZERO       16'h0000
// field positions
`define ASD_OP_LOCK_BIT    13
`define ASD_OP_EDGE_BIT    11
`define ASD_OP_OCHK_HI     10
`define ASD_OP_OCHK_LO     9
`define ASD_OP_ICHK_HI     8
`define ASD_OP_ICHK_LO     7
`define ASD_OP_MODE_HI     6
`define ASD_OP_MODE_LO     4
`define ASD_DG_ICHK_TOP    11
`define ASD_DG_FALLBACK    9
`define ASD_DG_THERM_EN    8
`define ASD_DG_TTALLY_HI   7
`define ASD_DG_TTALLY_LO   6
`define ASD_DG_OCHK_EN     5
`define ASD_DG_OTALLY_HI   4
`define ASD_DG_OTALLY_LO   3
`define ASD_DG_ICHK_EN     2
`define ASD_DG_ITALLY_HI   1
`define ASD_DG_ITALLY_LO   0
// scale figures, kept for reference by users of the decoded fields
`define ASD_ANGLE_LSB_UDEG 2750
`define ASD_TEMP_OFFSET    -50
`define ASD_EDGE_FAST_NS   150
`define ASD_EDGE_SLOW_NS   750
`define ASD_CLAMP_LO_PERMIL 50
`define ASD_CLAMP_HI_PERMIL 695
`endif

/* common/asd_pkg.sv */
// types for the angle sensor configuration bank and decoder
`default_nettype none
package asd_pkg;
    typedef enum logic [2:0] {
        ASD_OUT_DIGITAL = 3'h0,
        ASD_OUT_DIGITAL_N = 3'h1,
        ASD_OUT_ANALOG_M1 = 3'h4,
        ASD_OUT_ANALOG_M2 = 3'h5,
        ASD_OUT_ANALOG_M3 = 3'h6,
        ASD_OUT_ANALOG_STD = 3'h7
    } asd_out_mode_t;

    typedef enum logic [2:0] {
        ASD_LD_IDLE = 3'b001,
        ASD_LD_COPY = 3'b010,
        ASD_LD_DONE = 3'b100
    } asd_load_state_t;

    // angle words, unsigned, fixed lsb weight
    typedef struct packed {
        logic [15:0] zero_offset;
        logic [15:0] input_span;
        logic [15:0] mode3_threshold;
    } asd_angle_t;

    typedef struct packed {
        logic [7:0] shutdown_temp_code;
        logic [7:0] warning_temp_code;
        logic [7:0] low_clamp_code;
        logic [7:0] high_clamp_code;
    } asd_levels_t;

    typedef struct packed {
        logic          memory_write_lock;
        logic          data_edge_rate;
        logic [1:0]    output_check_strictness;
        logic [2:0]    input_check_strictness;
        asd_out_mode_t output_mode_select;
        logic          auto_return_normal;
        logic          thermal_watch_enable;
        logic [3:0]    thermal_fault_limit;
        logic          output_check_enable;
        logic [3:0]    output_fault_limit;
        logic          input_check_enable;
        logic [3:0]    input_fault_limit;
        logic          output_tally_valid;
    } asd_ctrl_t;
endpackage : asd_pkg
`default_nettype wire

/* core/asd_config_bank.sv */
// configuration word bank with power-on copy and field decoder
`include "asd_defines.svh"
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Function
// - angle words unsigned, fixed lsb weight
// - write lock bit 13, needs valid checksum
// - bit 11 selects slow data edges
// - bits 10:9 output check strictness
// - three-bit input strictness split across words
// - bits 6:4 select output mode
// - fallback bit 9, needs valid checksum
// - bit 8 enables thermal supervision
// - thermal tally code gives 0,2,4,8
// - bit 5 enables output check
// - output tally code 01 two, 10 four
// - bit 2 enables input check
// - input tally code gives 0,2,4,8
// - clamp word: low high byte, high low byte
// - copy stored words 0-F at power-on
// - program command ignored when lock latched
module asd_config_bank #(
    parameter int WORDS = `ASD_NUM_WORDS
) (
    input  wire logic                core_clk,
    input  wire logic                rst,
    // command port, from the serial front end on this clock
    input  wire logic                cmd_valid,
    input  wire logic [7:0]          cmd_byte,
    input  wire logic [15:0]         cmd_data,
    output logic [15:0]              rd_data,
    output logic                     rd_valid,
    // non-volatile store interface
    output logic [3:0]               nv_addr,
    input  wire logic [15:0]         nv_data,
    input  wire logic                crc_valid,
    output logic                     load_done,
    output logic                     program_start,
    // decoded fields
    output asd_pkg::asd_angle_t      angle_cfg,
    output asd_pkg::asd_levels_t     level_cfg,
    output asd_pkg::asd_ctrl_t       ctrl_cfg
);
    ////////////////////////////////////////////////////////////////////////////
    logic [15:0]              ram_r [WORDS];
    asd_pkg::asd_load_state_t ld_state_r;
    logic [3:0]               ld_idx_r;
    logic                     lock_latched_r;
    logic                     crc_latched_r;
    logic                     is_write;
    logic                     is_read;
    logic                     is_program;

    assign is_write   = cmd_valid && (cmd_byte[7:4] == `ASD_CMD_WRITE_HI) && (ld_state_r == asd_pkg::ASD_LD_DONE);
    assign is_read    = cmd_valid && (cmd_byte[7:4] == `ASD_CMD_READ_HI) && (ld_state_r == asd_pkg::ASD_LD_DONE);
    assign is_program = cmd_valid && (cmd_byte == `ASD_CMD_PROGRAM) && (ld_state_r == asd_pkg::ASD_LD_DONE);
    assign nv_addr    = ld_idx_r;
    assign load_done  = (ld_state_r == asd_pkg::ASD_LD_DONE);

    ////////////////////////////////////////////////////////////////////////////
    // power-on copy: one word per cycle, store data must follow nv_addr combinationally
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            ld_state_r <= asd_pkg::ASD_LD_IDLE;
            ld_idx_r   <= 4'h0;
        end
        else
        begin
            case (ld_state_r)
                asd_pkg::ASD_LD_IDLE:
                begin
                    ld_state_r <= asd_pkg::ASD_LD_COPY;
                end
                asd_pkg::ASD_LD_COPY:
                begin
                    ld_idx_r <= ld_idx_r + 4'h1;
                    if (ld_idx_r == 4'hF)
                    begin
                        ld_state_r <= asd_pkg::ASD_LD_DONE;
                    end
                end
                asd_pkg::ASD_LD_DONE:
                begin
                    ld_state_r <= asd_pkg::ASD_LD_DONE;
                end
                default:
                begin
                    ld_state_r <= asd_pkg::ASD_LD_IDLE;
                end
            endcase
        end
    end

    // ram: loaded from store, then host writes by word address
    always_ff @(posedge core_clk)
    begin
        if (ld_state_r == asd_pkg::ASD_LD_COPY)
        begin
            ram_r[ld_idx_r] <= nv_data;
        end
        else if (is_write)
        begin
            ram_r[cmd_byte[3:0]] <= cmd_data;
        end
    end

    // lock and checksum are caught once, at the end of the copy; later writes do not unlock
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            lock_latched_r <= 1'b0;
            crc_latched_r  <= 1'b0;
        end
        else if ((ld_state_r == asd_pkg::ASD_LD_COPY) && (ld_idx_r == 4'hF))
        begin
            crc_latched_r  <= crc_valid;
            lock_latched_r <= crc_valid && ram_r[`ASD_ADDR_OPCFG][`ASD_OP_LOCK_BIT];
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            program_start <= 1'b0;
            rd_valid      <= 1'b0;
            rd_data       <= 16'h0000;
        end
        else
        begin
            program_start <= is_program && !lock_latched_r;
            rd_valid      <= is_read;
            if (is_read)
            begin
                rd_data <= ram_r[cmd_byte[3:0]];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // decode: outputs are registered so they only move when the word moves
    function automatic logic [3:0] tally(input logic [1:0] code);
        tally = (code == 2'b00) ? 4'h0 : (4'h1 << code);
    endfunction

    logic [15:0] op_w;
    logic [15:0] dg_w;
    assign op_w = ram_r[`ASD_ADDR_OPCFG];
    assign dg_w = ram_r[`ASD_ADDR_DIAGCFG];

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            angle_cfg <= '0;
            level_cfg <= {`ASD_RST_THERMAL, `ASD_RST_CLAMP};
        end
        else if (load_done)
        begin
            angle_cfg.zero_offset     <= ram_r[`ASD_ADDR_ZERO];
            angle_cfg.input_span      <= ram_r[`ASD_ADDR_SPAN];
            angle_cfg.mode3_threshold <= ram_r[`ASD_ADDR_THRESH];
            level_cfg.shutdown_temp_code <= ram_r[`ASD_ADDR_THERMAL][15:8];
            level_cfg.warning_temp_code  <= ram_r[`ASD_ADDR_THERMAL][7:0];
            level_cfg.low_clamp_code     <= ram_r[`ASD_ADDR_CLAMP][15:8];
            level_cfg.high_clamp_code    <= ram_r[`ASD_ADDR_CLAMP][7:0];
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            ctrl_cfg <= '0;
            ctrl_cfg.output_mode_select   <= asd_pkg::ASD_OUT_ANALOG_M1;
            ctrl_cfg.auto_return_normal   <= 1'b1;
            ctrl_cfg.thermal_watch_enable <= 1'b1;
            ctrl_cfg.input_check_enable   <= 1'b1;
        end
        else if (load_done)
        begin
            ctrl_cfg.memory_write_lock       <= lock_latched_r;
            ctrl_cfg.data_edge_rate          <= op_w[`ASD_OP_EDGE_BIT];
            ctrl_cfg.output_check_strictness <= op_w[`ASD_OP_OCHK_HI:`ASD_OP_OCHK_LO];
            ctrl_cfg.input_check_strictness  <= {dg_w[`ASD_DG_ICHK_TOP],
                                                 op_w[`ASD_OP_ICHK_HI:`ASD_OP_ICHK_LO]};
            // undefined mode codes 010 and 011 pass through unchanged for the output stage to reject
            ctrl_cfg.output_mode_select      <= asd_pkg::asd_out_mode_t'(op_w[`ASD_OP_MODE_HI:`ASD_OP_MODE_LO]);
            ctrl_cfg.auto_return_normal      <= crc_latched_r && dg_w[`ASD_DG_FALLBACK];
            ctrl_cfg.thermal_watch_enable    <= dg_w[`ASD_DG_THERM_EN];
            ctrl_cfg.thermal_fault_limit     <= tally(dg_w[`ASD_DG_TTALLY_HI:`ASD_DG_TTALLY_LO]);
            ctrl_cfg.output_check_enable     <= dg_w[`ASD_DG_OCHK_EN];
            ctrl_cfg.output_fault_limit      <= tally(dg_w[`ASD_DG_OTALLY_HI:`ASD_DG_OTALLY_LO]);
            ctrl_cfg.output_tally_valid      <= (dg_w[`ASD_DG_OTALLY_HI] ^ dg_w[`ASD_DG_OTALLY_LO]);
            ctrl_cfg.input_check_enable      <= dg_w[`ASD_DG_ICHK_EN];
            ctrl_cfg.input_fault_limit       <= tally(dg_w[`ASD_DG_ITALLY_HI:`ASD_DG_ITALLY_LO]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    program_gate_a: assert property (@(posedge core_clk) disable iff (rst)
        program_start |-> ($past(is_program) && !$past(lock_latched_r)))
        else $error("program started while locked");
    lock_hold_a: assert property (@(posedge core_clk) disable iff (rst)
        (load_done && $past(load_done)) |-> $stable(lock_latched_r))
        else $error("lock changed after load");
    edge_decode_a: assert property (@(posedge core_clk) disable iff (rst)
        (load_done && $past(load_done)) |-> ctrl_cfg.data_edge_rate == $past(op_w[`ASD_OP_EDGE_BIT]))
        else $error("edge rate mismatch");
    mode_decode_a: assert property (@(posedge core_clk) disable iff (rst)
        $past(load_done) |-> ctrl_cfg.output_mode_select == $past(op_w[6:4]))
        else $error("output mode mismatch");
    tally_code_a: assert property (@(posedge core_clk) disable iff (rst)
        ($past(load_done) && $past(dg_w[7:6]) == 2'b11) |-> ctrl_cfg.thermal_fault_limit == 4'h8)
        else $error("thermal tally wrong");
    input_tally_a: assert property (@(posedge core_clk) disable iff (rst)
        ($past(load_done) && $past(dg_w[1:0]) == 2'b00) |-> ctrl_cfg.input_fault_limit == 4'h0)
        else $error("input tally wrong");
    fallback_gate_a: assert property (@(posedge core_clk) disable iff (rst)
        ctrl_cfg.auto_return_normal && load_done && $past(load_done) |-> crc_latched_r)
        else $error("fallback without checksum");
    field_stable_a: assert property (@(posedge core_clk) disable iff (rst)
        // the field seen now was built from the words one cycle back, so those must match
        (load_done && $past(load_done,2) && ($past(dg_w) == $past(dg_w,2)) && ($past(op_w) == $past(op_w,2)))
        |-> $stable(ctrl_cfg.input_check_strictness))
        else $error("field moved with word fixed");
    load_len_a: assert property (@(posedge core_clk) disable iff (rst)
        $rose(load_done) |-> $past(ld_idx_r) == 4'hF)
        else $error("copy ended early");
endmodule // asd_config_bank
`default_nettype wire

/* tb/asd_nv_store.sv */
// non-volatile store model feeding the power-on copy of the bank
`default_nettype none
module asd_nv_store (
    input  wire logic [3:0]  nv_addr,
    input  wire logic        crc_ok,
    output logic      [15:0] nv_data,
    output logic             crc_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [16];
    initial
    begin
        for (int i = 0; i < 16; i++)
            mem[i] = 16'h1357 * i[15:0];
        mem[7] = 16'h4F56;
        mem[8] = 16'h0DAB;
    end
    // combinational: the copy expects the word in the cycle of its address
    assign nv_data   = mem[nv_addr];
    assign crc_valid = crc_ok;
endmodule // asd_nv_store
`default_nettype wire

/* tb/tb_angle_sensor_config_decode.sv */
// self-checking bench for the configuration bank
`include "asd_defines.svh"
`default_nettype none
module tb_angle_sensor_config_decode;
    timeunit 1ns;
    timeprecision 1ps;
    logic                 core_clk, rst, cmd_valid, crc_ok, crc_valid;
    logic                 rd_valid, load_done, program_start, seen_load;
    logic [7:0]           cmd_byte;
    logic [3:0]           nv_addr;
    logic [15:0]          cmd_data, rd_data, nv_data;
    logic [31:0]          w;
    asd_pkg::asd_angle_t  angle_cfg;
    asd_pkg::asd_levels_t level_cfg;
    asd_pkg::asd_ctrl_t   ctrl_cfg;
    logic [15:0]          ram [16];
    logic [15:0]          rd_q [$];
    logic [3:0]           addrs [5] = '{4'h2, 4'h3, 4'h4, 4'h6, 4'h9};
    int                   n_errors = 0, compares = 0, n_prog = 0, edges = 0, seed = 22549;

    asd_config_bank dut (.core_clk(core_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
        .cmd_data(cmd_data), .rd_data(rd_data), .rd_valid(rd_valid), .nv_addr(nv_addr), .nv_data(nv_data),
        .crc_valid(crc_valid), .load_done(load_done), .program_start(program_start),
        .angle_cfg(angle_cfg), .level_cfg(level_cfg), .ctrl_cfg(ctrl_cfg));
    asd_nv_store store (.nv_addr(nv_addr), .crc_ok(crc_ok), .nv_data(nv_data), .crc_valid(crc_valid));

    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [47:0] e, input logic [47:0] s);
        compares++;
        if (s !== e)
        begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, e, s);
        end
    endtask
    function automatic logic [3:0] cnt(input logic [1:0] c);
        return (c == 2'b00) ? 4'h0 : 4'h1 << c;
    endfunction
    function automatic asd_pkg::asd_ctrl_t exp_ctrl(input logic [15:0] w1, w2, input logic crc);
        asd_pkg::asd_ctrl_t c;
        c.memory_write_lock       = 1'b0;
        c.data_edge_rate          = w1[11];
        c.output_check_strictness = w1[10:9];
        c.input_check_strictness  = {w2[11], w1[8:7]};
        c.output_mode_select      = asd_pkg::asd_out_mode_t'(w1[6:4]);
        c.auto_return_normal      = w2[9] & crc;
        c.thermal_watch_enable    = w2[8];
        c.thermal_fault_limit     = cnt(w2[7:6]);
        c.output_check_enable     = w2[5];
        c.output_fault_limit      = cnt(w2[4:3]);
        c.output_tally_valid      = w2[4] ^ w2[3];
        c.input_check_enable      = w2[2];
        c.input_fault_limit       = cnt(w2[1:0]);
        return c;
    endfunction
    // lock is seen through the program pulse; undefined tally counts are not judged
    function automatic asd_pkg::asd_ctrl_t mask(input asd_pkg::asd_ctrl_t c);
        c.memory_write_lock = 1'b0;
        if (c.output_tally_valid !== 1'b1)
            c.output_fault_limit = 4'h0;
        return c;
    endfunction
    task automatic chk_fields(input logic crc);
        chk("ctrl_cfg", 48'(mask(exp_ctrl(ram[7], ram[8], crc))), 48'(mask(ctrl_cfg)));
        chk("angle_cfg", {ram[2], ram[3], ram[4]}, angle_cfg);
        chk("level_cfg", 48'({ram[6], ram[9]}), 48'(level_cfg));
    endtask
    task automatic send(input logic [7:0] b, input logic [15:0] d);
        @(negedge core_clk);
        cmd_valid = 1'b1;
        cmd_byte  = b;
        cmd_data  = d;
        if (b[7:4] == `ASD_CMD_WRITE_HI && load_done === 1'b1)
            ram[b[3:0]] = d;
        if (b[7:4] == `ASD_CMD_READ_HI)
            rd_q.push_back(ram[b[3:0]]);
    endtask
    task automatic idle(input int n);
        @(negedge core_clk);
        cmd_valid = 1'b0;
        cmd_data  = 16'($random(seed));
        repeat (n) @(negedge core_clk);
    endtask
    task automatic do_reset(input logic crc);
        @(negedge core_clk);
        rst    = 1'b1;
        crc_ok = crc;
        repeat (20) @(negedge core_clk);
        chk("rst_ctrl", 48'(mask(exp_ctrl(`ASD_RST_OPCFG, `ASD_RST_DIAGCFG, 1'b1))), 48'(mask(ctrl_cfg)));
        chk("rst_level", 48'({`ASD_RST_THERMAL, `ASD_RST_CLAMP}), 48'(level_cfg));
        chk("rst_pulses", 48'h0, 48'({rd_valid, program_start, load_done}));
        rst = 1'b0;
        // a write before the copy ends must be dropped
        send({`ASD_CMD_WRITE_HI, 4'h2}, 16'hBEEF);
        idle(0);
        for (int n = 0; n < 40 && load_done !== 1'b1; n++)
            @(negedge core_clk);
        chk("load_done", 48'h1, 48'(load_done));
        // decoded fields follow the ram one cycle after the copy ends
        @(negedge core_clk);
        for (int i = 0; i < 16; i++)
            ram[i] = store.mem[i];
        chk_fields(crc);
        chk("lock", 48'(crc & store.mem[`ASD_ADDR_OPCFG][`ASD_OP_LOCK_BIT]), 48'(ctrl_cfg.memory_write_lock));
    endtask
    task automatic results;
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    always @(posedge core_clk)
        edges <= rst ? 0 : edges + 1;
    always @(negedge core_clk)
    begin
        if (rst === 1'b1)
            seen_load = 1'b0;
        else if (load_done === 1'b1 && seen_load !== 1'b1)
        begin
            seen_load = 1'b1;
            chk("load_edge", 48'(1 + `ASD_NUM_WORDS), 48'(edges));
        end
        if (program_start === 1'b1)
            n_prog++;
        if (rd_valid === 1'b1)
        begin
            if (rd_q.size() == 0)
                chk("rd_unexpected", 48'h0, 48'h1);
            else
                chk("rd_data", 48'(rd_q.pop_front()), 48'(rd_data));
        end
    end
    initial
    begin
        repeat (20000) @(posedge core_clk);
        n_errors++;
        $display("Error watchdog expected finish seen hang");
        results;
    end
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        rst       = 1'b1;
        cmd_valid = 1'b0;
        cmd_byte  = 8'h00;
        cmd_data  = 16'h0000;
        crc_ok    = 1'b1;
        do_reset(1'b1);
        for (int a = 0; a < 16; a++)
            send({`ASD_CMD_READ_HI, 4'(a)}, 16'h0000);
        for (int i = 0; i < 16; i++)
        begin
            w = $random(seed);
            // fixed bits written as shown, every mode code visited twice
            send({`ASD_CMD_WRITE_HI, `ASD_ADDR_OPCFG}, {4'h4, w[11:7], 3'(i), 4'h6});
            send({`ASD_CMD_WRITE_HI, `ASD_ADDR_DIAGCFG}, {4'h0, w[31], 1'b1, w[25:16]});
            foreach (addrs[k])
                send({`ASD_CMD_WRITE_HI, addrs[k]}, 16'($random(seed)));
            idle(1);
            chk_fields(1'b1);
            send({`ASD_CMD_WRITE_HI, 4'hA}, 16'($random(seed)));
            send({`ASD_CMD_READ_HI, `ASD_ADDR_OPCFG}, 16'h0000);
            send({`ASD_CMD_READ_HI, `ASD_ADDR_DIAGCFG}, 16'h0000);
            idle(1);
            chk_fields(1'b1);
        end
        // lock taken at power-on: a later ram lock bit does not block programming
        send(`ASD_CMD_PROGRAM, 16'h0000);
        send({`ASD_CMD_WRITE_HI, `ASD_ADDR_OPCFG}, 16'h6046);
        send(`ASD_CMD_PROGRAM, 16'h0000);
        idle(2);
        store.mem[7] = 16'h6046;
        store.mem[8] = 16'h0704;
        do_reset(1'b1);
        send(`ASD_CMD_PROGRAM, 16'h0000);
        idle(2);
        // checksum bad: lock and fallback both ignored
        do_reset(1'b0);
        send(`ASD_CMD_PROGRAM, 16'h0000);
        idle(3);
        chk("program_pulses", 48'd3, 48'(n_prog));
        chk("reads_pending", 48'd0, 48'(rd_q.size()));
        results;
    end
endmodule // tb_angle_sensor_config_decode
`default_nettype wire
